// ==== qsqc_queue_ctrl.sv ====
// Queued serial master: run control, delays, queue sequencing and interrupts
//
// Notes on behaviour
// R1 - Setting run enable starts executing queue
// R2 - Run enable clears itself when queue completes
// R3 - Writing run zero aborts unless locked out; errors and is dropped instead if abort bus error enabled
// R4 - Software should prefer halt over clearing run
// R5 - Clock delay select inserts chip-select-to-clock delay
// R6 - Post delay select inserts delay after transfer
// R7 - Halt finishes current entry, then stops
// R8 - Wraparound off stops at end; on restarts
// R9 - Wrap target: entry zero or start pointer
// R10 - Idle level sets inactive chip select polarity
// R11 - End pointer indexes last queue entry
// R12 - Completed pointer tracks last done, read only
// R13 - Execution begins at start pointer entry
// R14 - Finished flag on end, wrap, halt; W1C
// R15 - Abort flag when software clears run; W1C
// R16 - Collision flag on write to executing entry
// R17 - Abort lock-out blocks software clearing run
// R18 - Interrupt when enabled flag is set
// R19 - Interrupt register resets to zero
`timescale 1ns/1ps
module qsqc_queue_ctrl #(
   parameter int unsigned BITS_PER_ENTRY = qsqc_pkg::XFER_BITS
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial side
   input  wire logic        link_clk,
   output logic [3:0]       chip_select,
   output logic             serial_run,
   // Interrupt
   output logic             irq
);

   qsqc_pkg::qsqc_state_t r_reg;
   qsqc_pkg::qsqc_state_t r_next;

   logic       link_rise;
   logic [7:0] ram_rdata;
   logic       ram_wr_en;
   logic [3:0] ram_wr_addr;

   // Command window hit
   function automatic logic is_cmd(input logic [11:0] a);
      is_cmd = (a >= qsqc_pkg::ADDR_CMD_BASE) && (a <= qsqc_pkg::ADDR_CMD_LAST)
               && (a[1:0] == 2'h0);
   endfunction

   // Command entry index from address
   function automatic logic [3:0] cmd_index(input logic [11:0] a);
      logic [11:0] off;
      off       = a - qsqc_pkg::ADDR_CMD_BASE;
      cmd_index = off[5:2];
   endfunction

   // Pin level of the chip selects for an entry
   function automatic logic [3:0] cs_level(input logic idle_hi, input logic [3:0] sel);
      cs_level = idle_hi ? ~sel : sel;
   endfunction

   // Link clock enters through two flops before any edge logic
   qsqc_edge_sync u_link_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (link_clk),
      .rise     (link_rise)
   );

   // Command entries, read at the executing index
   qsqc_cmd_ram #(
      .DEPTH (16),
      .AW    (4)
   ) u_cmd_ram (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (ram_wr_en),
      .wr_addr (ram_wr_addr),
      .wr_data (pwdata[7:0]),
      .rd_addr (r_reg.idx),
      .rd_data (ram_rdata)
   );

   logic setup;
   logic access;
   logic busy;
   logic collide;
   logic hit_rd;
   logic hit_wr;
   logic hit_iq;
   logic hit_cmd;
   logic clear_try;

   // Bus phase and decode terms
   always_comb
   begin
      setup     = psel & ~penable;
      access    = psel & penable & r_reg.pready;
      busy      = (r_reg.st != qsqc_pkg::ST_IDLE);
      hit_rd    = (paddr == qsqc_pkg::ADDR_RUN_DELAY);
      hit_wr    = (paddr == qsqc_pkg::ADDR_WRAP);
      hit_iq    = (paddr == qsqc_pkg::ADDR_IRQ);
      hit_cmd   = is_cmd(paddr);
      collide   = hit_cmd & pwrite & busy & (cmd_index(paddr) == r_reg.idx);
      clear_try = hit_rd & pwrite & ~pwdata[15] & r_reg.rd.queue_run_enable;
   end

   // Command memory write; an erroring write is dropped
   assign ram_wr_en   = access & pwrite & hit_cmd & ~r_reg.pslverr;
   assign ram_wr_addr = cmd_index(paddr);

   // Next state: sequencer first, then bus effects, flag sets last so they win
   always_comb
   begin
      logic fin_set;
      logic abort_set;
      logic coll_set;
      fin_set   = 1'b0;
      abort_set = 1'b0;
      coll_set  = 1'b0;
      r_next    = r_reg;
      r_next.pready  = 1'b0;
      r_next.pslverr = 1'b0;

      // Queue sequencer
      case (r_reg.st)
         qsqc_pkg::ST_IDLE:
         begin
            r_next.cs         = {4{r_reg.wr.chip_select_idle_level}}; // R10
            r_next.serial_run = 1'b0;
            if (r_reg.rd.queue_run_enable) // R1
            begin
               r_next.idx = r_reg.wr.start_pointer; // R13
               r_next.st  = qsqc_pkg::ST_LOAD;
            end
         end
         qsqc_pkg::ST_LOAD:
         begin
            // Memory read data is valid one cycle later
            r_next.st = qsqc_pkg::ST_SELECT;
         end
         qsqc_pkg::ST_SELECT:
         begin
            r_next.cmd = qsqc_pkg::qsqc_cmd_t'(ram_rdata);
            r_next.cs  = cs_level(r_reg.wr.chip_select_idle_level, ram_rdata[3:0]); // R10
            r_next.cnt = ram_rdata[7] ? {1'b0, r_reg.rd.cs_to_clock_delay} : 8'h00; // R5
            r_next.st  = qsqc_pkg::ST_CS_DLY;
         end
         qsqc_pkg::ST_CS_DLY:
         begin
            if (r_reg.cnt == 8'h00) // R5
            begin
               r_next.st         = qsqc_pkg::ST_XFER;
               r_next.serial_run = 1'b1;
            end
            else
            begin
               r_next.cnt = r_reg.cnt - 8'h01;
            end
         end
         qsqc_pkg::ST_XFER:
         begin
            // Each sampled rising link edge is one serial bit
            if (link_rise)
            begin
               if (r_reg.cnt == 8'(BITS_PER_ENTRY - 1))
               begin
                  r_next.serial_run = 1'b0;
                  r_next.cnt = r_reg.cmd.post_delay_select
                               ? r_reg.rd.post_transfer_delay : 8'h00; // R6
                  r_next.st  = qsqc_pkg::ST_POST;
               end
               else
               begin
                  r_next.cnt = r_reg.cnt + 8'h01;
               end
            end
         end
         qsqc_pkg::ST_POST:
         begin
            if (r_reg.cnt != 8'h00) // R6
            begin
               r_next.cnt = r_reg.cnt - 8'h01;
            end
            else
            begin
               // Entry complete
               r_next.wr.completed_pointer = r_reg.idx; // R12
               r_next.cs = {4{r_reg.wr.chip_select_idle_level}};
               r_next.cnt = 8'h00;
               if (r_reg.wr.halt_request) // R7
               begin
                  fin_set = 1'b1; // R14
                  r_next.rd.queue_run_enable = 1'b0; // R2
                  r_next.st = qsqc_pkg::ST_IDLE;
               end
               else if (r_reg.idx == r_reg.wr.end_pointer) // R11
               begin
                  fin_set = 1'b1; // R14
                  if (r_reg.wr.wraparound_enable) // R8
                  begin
                     r_next.idx = r_reg.wr.wrap_target_select
                                  ? r_reg.wr.start_pointer : 4'h0; // R9
                     r_next.st  = qsqc_pkg::ST_LOAD;
                  end
                  else
                  begin
                     r_next.rd.queue_run_enable = 1'b0; // R2
                     r_next.st = qsqc_pkg::ST_IDLE;
                  end
               end
               else
               begin
                  // Index wraps past entry 15 naturally
                  r_next.idx = r_reg.idx + 4'h1;
                  r_next.st  = qsqc_pkg::ST_LOAD;
               end
            end
         end
         default:
         begin
            r_next.st = qsqc_pkg::ST_IDLE;
         end
      endcase

      // Setup cycle: prepare answer so the access phase has no wait state
      if (setup)
      begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h0000_0000;
         if (hit_rd)
         begin
            r_next.prdata[15:0] = r_reg.rd;
         end
         else if (hit_wr)
         begin
            r_next.prdata[15:0] = r_reg.wr;
         end
         else if (hit_iq)
         begin
            r_next.prdata[15:0] = r_reg.iq;
         end
         // Command window reads as zero; the memory port serves the sequencer
         r_next.pslverr = ~(hit_rd | hit_wr | hit_iq | hit_cmd)
                          | (collide & r_reg.iq.collision_bus_error_enable)
                          | (clear_try & busy & ~r_reg.iq.abort_lockout
                             & r_reg.iq.abort_bus_error_enable);
      end

      // Access phase: writes and read side effects take place here
      if (access)
      begin
         if (pwrite & collide)
         begin
            coll_set = 1'b1; // R16
         end
         if (pwrite & hit_rd & ~r_reg.pslverr)
         begin
            r_next.rd.cs_to_clock_delay   = pwdata[14:8];
            r_next.rd.post_transfer_delay = pwdata[7:0];
            if (pwdata[15])
            begin
               r_next.rd.queue_run_enable = 1'b1; // R1
            end
            else if (~r_reg.iq.abort_lockout) // R17
            begin
               r_next.rd.queue_run_enable = 1'b0; // R3
               r_next.st         = qsqc_pkg::ST_IDLE;
               r_next.serial_run = 1'b0;
               r_next.cs         = {4{r_reg.wr.chip_select_idle_level}};
               abort_set         = r_reg.rd.queue_run_enable; // R15
            end
         end
         if (pwrite & hit_wr)
         begin
            // Completed pointer ignores writes
            r_next.wr = qsqc_pkg::qsqc_wrap_t'((pwdata[15:0] & qsqc_pkg::WRAP_WR_MASK)
                        | ({8'h00, r_next.wr.completed_pointer, 4'h0}
                           & ~qsqc_pkg::WRAP_WR_MASK)); // R12
         end
         if (pwrite & hit_iq)
         begin
            // Enables take the written value, flags clear where a one is written
            r_next.iq = qsqc_pkg::qsqc_irq_t'((pwdata[15:0] & qsqc_pkg::IRQ_ENABLE_MASK)
                        | (r_reg.iq & qsqc_pkg::IRQ_FLAG_MASK & ~pwdata[15:0])); // R14
         end
         if (~pwrite & hit_iq)
         begin
            // A read clears only the flags it returned, so a late set is not lost
            r_next.iq = qsqc_pkg::qsqc_irq_t'(r_reg.iq
                        & ~(r_reg.prdata[15:0] & qsqc_pkg::IRQ_FLAG_MASK));
         end
      end

      // Hardware sets beat a same-cycle clear
      if (fin_set)
      begin
         r_next.iq.finished_flag = 1'b1; // R14
      end
      if (abort_set)
      begin
         r_next.iq.abort_flag = 1'b1; // R15
      end
      if (coll_set)
      begin
         r_next.iq.write_collision_flag = 1'b1; // R16
      end

      // Level interrupt from the flags that will be held next cycle
      r_next.irq = (r_next.iq.finished_flag & r_next.iq.finished_irq_enable)
                   | (r_next.iq.abort_flag & r_next.iq.abort_irq_enable)
                   | (r_next.iq.write_collision_flag
                      & r_next.iq.collision_irq_enable); // R18
   end

   // State register; chip selects start idle low, matching the reset idle level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_reg    <= '0;
         r_reg.st <= qsqc_pkg::ST_IDLE;
         r_reg.rd <= qsqc_pkg::qsqc_run_delay_t'(qsqc_pkg::RUN_DELAY_RESET);
         r_reg.wr <= qsqc_pkg::qsqc_wrap_t'(qsqc_pkg::WRAP_RESET);
         r_reg.iq <= qsqc_pkg::qsqc_irq_t'(qsqc_pkg::IRQ_RESET); // R19
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state flops
   assign prdata      = r_reg.prdata;
   assign pready      = r_reg.pready;
   assign pslverr     = r_reg.pslverr;
   assign chip_select = r_reg.cs;
   assign serial_run  = r_reg.serial_run;
   assign irq         = r_reg.irq;

endmodule

// ==== qsqc_pkg.sv ====
// Shared constants, register layouts and state types of the queue controller
package qsqc_pkg;

   // Register byte addresses on APB
   localparam logic [11:0] ADDR_RUN_DELAY = 12'h344;
   localparam logic [11:0] ADDR_WRAP      = 12'h348;
   localparam logic [11:0] ADDR_IRQ       = 12'h34C;
   localparam logic [11:0] ADDR_CMD_BASE  = 12'h380;
   localparam logic [11:0] ADDR_CMD_LAST  = 12'h3BC;

   // Reset values
   localparam logic [15:0] RUN_DELAY_RESET = 16'h0000;
   localparam logic [15:0] WRAP_RESET      = 16'h0000;
   localparam logic [15:0] IRQ_RESET       = 16'h0000;

   // Writable bits of the wrap and interrupt registers
   localparam logic [15:0] WRAP_WR_MASK    = 16'hFF0F;
   localparam logic [15:0] IRQ_ENABLE_MASK = 16'hDD00;
   localparam logic [15:0] IRQ_FLAG_MASK   = 16'h000D;

   // Serial bits per command entry
   localparam int unsigned XFER_BITS = 8;

   // Delay and run control, bit 15 down to bit 0
   typedef struct packed {
      logic       queue_run_enable;
      logic [6:0] cs_to_clock_delay;
      logic [7:0] post_transfer_delay;
   } qsqc_run_delay_t;

   // Wrap control, bit 15 down to bit 0
   typedef struct packed {
      logic       halt_request;
      logic       wraparound_enable;
      logic       wrap_target_select;
      logic       chip_select_idle_level;
      logic [3:0] end_pointer;
      logic [3:0] completed_pointer;
      logic [3:0] start_pointer;
   } qsqc_wrap_t;

   // Interrupt enables and flags, bit 15 down to bit 0
   typedef struct packed {
      logic       collision_bus_error_enable;
      logic       abort_bus_error_enable;
      logic       rsv13;
      logic       abort_lockout;
      logic       collision_irq_enable;
      logic       abort_irq_enable;
      logic       rsv9;
      logic       finished_irq_enable;
      logic [3:0] rsv7_4;
      logic       write_collision_flag;
      logic       abort_flag;
      logic       rsv1;
      logic       finished_flag;
   } qsqc_irq_t;

   // One command entry
   typedef struct packed {
      logic       clock_delay_select;
      logic       post_delay_select;
      logic [1:0] rsv;
      logic [3:0] chip_selects;
   } qsqc_cmd_t;

   // Queue sequencer states
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_LOAD   = 6'b000010,
      ST_SELECT = 6'b000100,
      ST_CS_DLY = 6'b001000,
      ST_XFER   = 6'b010000,
      ST_POST   = 6'b100000
   } qsqc_state_e_t;

   // Whole state of the top module
   typedef struct packed {
      qsqc_state_e_t   st;
      qsqc_run_delay_t rd;
      qsqc_wrap_t      wr;
      qsqc_irq_t       iq;
      logic [3:0]      idx;
      logic [7:0]      cnt;
      qsqc_cmd_t       cmd;
      logic [3:0]      cs;
      logic            serial_run;
      logic            irq;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } qsqc_state_t;

endpackage

// ==== qsqc_cmd_ram.sv ====
// Command entry memory with registered read data
`timescale 1ns/1ps
module qsqc_cmd_ram #(
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW    = 4
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic [7:0]         rd_data
);

   logic [7:0] mem [DEPTH];

   // Storage has no reset; software loads entries before starting
   always_ff @(posedge pclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data always from a flop, one cycle after the address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_data <= 8'h00;
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ==== qsqc_edge_sync.sv ====
// Two-flop synchroniser with rising edge detector for the link clock
`timescale 1ns/1ps
module qsqc_edge_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Asynchronous level and its detected rising edge
   input  wire logic async_in,
   output logic      rise
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic rise;
   } qsqc_sync_t;

   qsqc_sync_t r_reg;
   qsqc_sync_t r_next;

   // Only the second stage and later are looked at
   always_comb
   begin
      r_next      = r_reg;
      r_next.meta = async_in;
      r_next.sync = r_reg.meta;
      r_next.last = r_reg.sync;
      r_next.rise = r_reg.sync & ~r_reg.last;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign rise = r_reg.rise;

endmodule

// ==== qsqc_checker_properties.sv ====
// Port-level properties of the queue controller
`timescale 1ns/1ps
module qsqc_checker #(
   parameter int unsigned BITS_PER_ENTRY = 8
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Serial side and interrupt
   input wire logic        link_clk,
   input wire logic [3:0]  chip_select,
   input wire logic        serial_run,
   input wire logic        irq
);
   logic       wr_ok;
   logic       hit;
   logic       idle_q;
   logic       lock_q;
   logic [2:0] ien_q;
   // Shadow only accepted writes; refused ones leave the settings alone
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign hit = paddr inside {qsqc_pkg::ADDR_RUN_DELAY, qsqc_pkg::ADDR_WRAP, qsqc_pkg::ADDR_IRQ}
      || (paddr >= qsqc_pkg::ADDR_CMD_BASE && paddr <= qsqc_pkg::ADDR_CMD_LAST
      && paddr[1:0] == 2'b00);
   // Idle level, lock-out and enables as software last set them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idle_q <= 1'b0;
         lock_q <= 1'b0;
         ien_q  <= 3'b000;
      end
      else if (wr_ok && paddr == qsqc_pkg::ADDR_WRAP)
         idle_q <= pwdata[12];
      else if (wr_ok && paddr == qsqc_pkg::ADDR_IRQ)
      begin
         lock_q <= pwdata[12];
         ien_q  <= {pwdata[11], pwdata[10], pwdata[8]};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_released;
      !serial_run && chip_select == {4{idle_q}};
   endsequence
   sequence s_abort_wr;
      wr_ok && paddr == qsqc_pkg::ADDR_RUN_DELAY && !pwdata[15] && !lock_q;
   endsequence
   a_setup_answer: assert property (s_setup |=> pready)
      else $error("no answer after setup");
   a_unmapped_error: assert property (psel && penable && pready && !hit
      |-> pslverr && (pwrite || prdata == 32'h00000000)) else $error("unmapped access");
   a_reset_quiet: assert property (presetn && !$past(presetn) |-> !irq && !serial_run && chip_select == 4'h0)
      else $error("outputs busy after reset");
   a_irq_masked: assert property (ien_q == 3'b000 && $past(ien_q) == 3'b000 |-> !irq)
      else $error("interrupt with all enables off");
   a_cs_driven: assert property (serial_run |-> chip_select != {4{idle_q}})
      else $error("chip select idle during frame");
   a_abort_stops: assert property (s_abort_wr |-> ##[1:2] s_released)
      else $error("abort did not stop the queue");
   a_lockout_quiet: assert property (psel && penable && pready && pwrite && lock_q
      && paddr == qsqc_pkg::ADDR_RUN_DELAY |-> !pslverr)
      else $error("locked run write refused");
   a_run_starts: assert property (wr_ok && paddr == qsqc_pkg::ADDR_RUN_DELAY && pwdata[15]
      && !serial_run && chip_select == {4{idle_q}} |-> ##[2:140] serial_run)
      else $error("queue did not start");
endmodule

// ==== qsqc_spi_peripheral.sv ====
// Serial peripheral model: gives the link clock only while a frame runs
`timescale 1ns/1ps
module qsqc_spi_peripheral (
   // Frame indication from the master
   input wire logic serial_run,
   // Link clock towards the master
   output logic     link_clk
);
   // Clock stands still between frames so no stray edge reaches the master
   initial
   begin
      link_clk = 1'b0;
      #13;
      forever
      begin
         #80;
         link_clk = serial_run ? ~link_clk : 1'b0;
      end
   end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the queue controller
`timescale 1ns/1ps
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        link_clk, serial_run, irq, err, idle_lvl, sr_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  chip_select, cs_q;
   logic [3:0]  cs_log[$];
   int          errors, compares, cycles, seg, lead, tail, i, s, e, n, m, c;
   logic [11:0] s_regs[3] = '{qsqc_pkg::ADDR_RUN_DELAY, qsqc_pkg::ADDR_WRAP, qsqc_pkg::ADDR_IRQ};
   logic [15:0] s_irq[3]  = '{16'h0400, 16'h1000, 16'h8800};
   logic [15:0] s_flag[3] = '{16'h0404, 16'h1001, 16'h8809};
   qsqc_queue_ctrl #(.BITS_PER_ENTRY(2)) qsqc_queue_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .chip_select(chip_select), .serial_run(serial_run), .irq(irq));
   qsqc_spi_peripheral qsqc_spi_peripheral_inst (.serial_run(serial_run), .link_clk(link_clk));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic final_report();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Frame log, lead and tail of chip select around frames, hang limit
   always @(posedge pclk)
   begin
      if (serial_run && !sr_q)
      begin
         cs_log.push_back(chip_select);
         lead = seg;
      end
      if (!serial_run && cs_q != {4{idle_lvl}} && chip_select == {4{idle_lvl}})
         tail = seg + 1;
      seg = (serial_run != sr_q || chip_select == {4{idle_lvl}}) ? 0 : seg + 1;
      sr_q = serial_run;
      cs_q = chip_select;
      cycles++;
      if (cycles == 80000)
      begin
         errors++;
         final_report();
      end
   end
   // Master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic poll_done();
      do
      begin
         apb(1'b0, qsqc_pkg::ADDR_RUN_DELAY, 16'h0000);
      end
      while (rdata[15] === 1'b1);
   endtask
   task automatic wait_serial();
      while (serial_run !== 1'b1)
      begin
         @(posedge pclk);
      end
   endtask
   function automatic logic [3:0] pat(input int j);
      return 4'(j + 1);
   endfunction
   function automatic logic [3:0] wrap_idx(input logic sel, input int j);
      int p;
      p = 2;
      for (int q = 0; q < j; q++)
         p = (p == 4) ? (sel ? 2 : 0) : p + 1;
      return 4'(p);
   endfunction
   initial
   begin
      {presetn, psel, penable, pwrite, idle_lvl, sr_q} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      cs_q = 4'h0;
      {errors, compares, cycles, seg, lead, tail} = 0;
      void'($urandom(32'h7B49));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, unmapped address, entries with distinct patterns
      foreach (s_regs[j])
      begin
         apb(1'b0, s_regs[j], 16'h0000);
         check("reset value", rdata, 32'h00000000);
      end
      apb(1'b0, 12'h300, 16'h0000);
      check("unmapped", {31'h0, err}, 32'h00000001);
      for (i = 0; i < 15; i++)
         apb(1'b1, 12'(qsqc_pkg::ADDR_CMD_BASE + 4 * i), {12'h000, pat(i)});
      $display("test reset done");
      // Random linear queues, idle level, read-only completed pointer
      for (c = 0; c < 3; c++)
      begin
         s = $urandom_range(0, 10);
         e = s + $urandom_range(0, 3);
         idle_lvl = 1'($urandom_range(0, 1));
         apb(1'b1, qsqc_pkg::ADDR_WRAP, {3'b000, idle_lvl, 4'(e), 4'hF, 4'(s)});
         apb(1'b1, qsqc_pkg::ADDR_IRQ, 16'h0100);
         cs_log.delete();
         apb(1'b1, qsqc_pkg::ADDR_RUN_DELAY, 16'h8000);
         poll_done();
         check("frames", 32'(cs_log.size()), 32'(e - s + 1));
         foreach (cs_log[j])
            check("cs", 32'(cs_log[j]), {28'h0, idle_lvl ? ~pat(s + j) : pat(s + j)});
         check("irq", 32'(irq), 32'h1);
         apb(1'b0, qsqc_pkg::ADDR_WRAP, 16'h0000);
         check("wrap", rdata, {19'h0, idle_lvl, 4'(e), 4'(e), 4'(s)});
         apb(1'b0, qsqc_pkg::ADDR_IRQ, 16'h0000);
         check("finished", 32'(rdata[0]), 32'h1);
         repeat (3) @(posedge pclk);
         check("irq off", 32'(irq), 32'h0);
      end
      $display("test queues done");
      // Lead and tail delays for every select combination
      idle_lvl = 1'b0;
      apb(1'b1, qsqc_pkg::ADDR_WRAP, 16'h0505);
      for (c = 0; c < 4; c++)
      begin
         n = $urandom_range(0, 31);
         m = $urandom_range(0, 31);
         apb(1'b1, 12'(qsqc_pkg::ADDR_CMD_BASE + 20), {8'h00, 2'(c), 2'b00, pat(5)});
         apb(1'b1, qsqc_pkg::ADDR_RUN_DELAY, {1'b1, 7'(n), 8'(m)});
         poll_done();
         s = (c[1] ? n : 0) + 1;
         e = (c[0] ? m : 0) + 1;
         check("lead", 32'(lead >= s && lead <= s + 2), 32'h1);
         check("tail", 32'(tail >= e && tail <= e + 2), 32'h1);
      end
      $display("test delays done");
      // Wraparound to entry zero and to the start pointer, then halt
      for (c = 0; c < 2; c++)
      begin
         cs_log.delete();
         apb(1'b1, qsqc_pkg::ADDR_WRAP, {2'b01, 1'(c), 5'h04, 8'h02});
         apb(1'b1, qsqc_pkg::ADDR_RUN_DELAY, 16'h8000);
         for (i = 0; i < 20000 && cs_log.size() < 7; i++)
            @(posedge pclk);
         apb(1'b1, qsqc_pkg::ADDR_WRAP, {2'b11, 1'(c), 5'h04, 8'h02});
         poll_done();
         for (i = 0; i < 7; i++)
            check("wrap order", 32'(cs_log[i]), 32'(pat(wrap_idx(1'(c), i))));
         check("halt stop", 32'(cs_log.size() <= 9), 32'h1);
         apb(1'b0, qsqc_pkg::ADDR_IRQ, 16'h0000);
         check("halt finished", 32'(rdata[0]), 32'h1);
      end
      $display("test wrap done");
      // Abort, abort lock-out and write collision on entry six
      apb(1'b1, qsqc_pkg::ADDR_WRAP, 16'h0606);
      apb(1'b1, 12'(qsqc_pkg::ADDR_CMD_BASE + 24), {8'h00, 4'h4, pat(6)});
      foreach (s_irq[j])
      begin
         apb(1'b1, qsqc_pkg::ADDR_IRQ, s_irq[j]);
         apb(1'b1, qsqc_pkg::ADDR_RUN_DELAY, 16'h80FF);
         wait_serial();
         if (j == 2)
            apb(1'b1, 12'(qsqc_pkg::ADDR_CMD_BASE + 24), {8'h00, 4'h4, pat(6)});
         else
            apb(1'b1, qsqc_pkg::ADDR_RUN_DELAY, 16'h00FF);
         if (j == 2)
            check("collision err", 32'(err), 32'h1);
         apb(1'b0, qsqc_pkg::ADDR_RUN_DELAY, 16'h0000);
         check("run after", 32'(rdata[15]), 32'(j != 0));
         poll_done();
         apb(1'b0, qsqc_pkg::ADDR_IRQ, 16'h0000);
         check("flags", rdata, 32'(s_flag[j]));
      end
      $display("test abort done");
      final_report();
   end
endmodule
bind qsqc_queue_ctrl qsqc_checker #(.BITS_PER_ENTRY(BITS_PER_ENTRY)) qsqc_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .link_clk(link_clk), .chip_select(chip_select), .serial_run(serial_run), .irq(irq));
